// ---- design/ledsc_cfg.svh ----
// constants for the led display serial command block
// What this block does
// - after reset the dimming width is the narrowest step, the display is blanked and key scanning already runs.
// - one key scan cycle spans exactly two display frames before the key data counts as refreshed.
// - the ten-source by two-return key matrix is captured into key storage that a read command returns.
// - the serial output only pulls low or releases and never drives high.
// - in incrementing write mode the display address advances by one after each stored data byte.
// - a display control byte of 80 hex turns the display off while scanning continues.
// - the first byte after the strobe falls is a command and a strobe rise mid-byte discards the partial byte.
// - input bits are sampled on rising shift-clock edges, and the clock is ignored while the strobe is high.
// - output changes on falling edges, except that it is released on the rising edge after each eighth bit.
// - addresses zero to thirteen are valid and data is ignored while the address is fourteen or more.
// - key bytes are sent least significant bit first and continue straight into the next byte.
`ifndef LEDSC_CFG_SVH
`define LEDSC_CFG_SVH
`define LEDSC_RAM_DEPTH 14
`define LEDSC_ADDR_LAST 4'hD
`define LEDSC_KEY_BYTES 5
`define LEDSC_PW_RESET 3'h0
`define LEDSC_MODE_RESET 2'h3
`define LEDSC_DISP_OFF_BYTE 8'h80
`define LEDSC_CLK_HZ 10000000
`define LEDSC_FRAME_US 2000
`define LEDSC_FRAME_CYC ((`LEDSC_FRAME_US * (`LEDSC_CLK_HZ / 1000000)))
`define LEDSC_FRAMES_PER_SCAN 2
`endif

// ---- design/ledsc_pkg.sv ----
// types shared by the led display serial command block
package ledsc_pkg;
    typedef enum logic [1:0] {
        LEDSC_CMD_MODE,
        LEDSC_CMD_DATA,
        LEDSC_CMD_ADDR,
        LEDSC_CMD_CTRL
    } ledsc_cmd_t;
    typedef struct packed {
        logic on;
        logic [2:0] pulse_width;
    } ledsc_disp_t;
    typedef struct packed {
        logic [1:0] key_return;
        logic [9:0] key_source;
    } ledsc_keys_t;
endpackage

// ---- design/ledsc_fifo.sv ----
// small valid/ready fifo holding received write bytes
`timescale 1ns/10ps
module ledsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            if (pop) rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge clk) begin
        if (push) mem_ff[wr_ff] <= in_data;
    end
endmodule

// ---- design/ledsc_top.sv ----
// serial command, display ram and key scan path of the led driver
`timescale 1ns/10ps
`include "ledsc_cfg.svh"
module ledsc_top #(
    parameter int FRAME_CYC = `LEDSC_FRAME_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link pins
    input wire logic frame_select,
    input wire logic shift_clk,
    input wire logic data_in,
    output logic data_out,
    output logic data_oe,
    // key matrix
    input wire logic key_return_a,
    input wire logic key_return_b,
    output logic [9:0] key_source_line,
    // display state
    output ledsc_pkg::ledsc_disp_t disp_ctrl,
    output logic [1:0] disp_mode,
    output logic [3:0] ram_rd_addr,
    output logic [7:0] ram_rd_data,
    output logic scan_done
);
    import ledsc_pkg::*;
    // three-stage synchronisers, change counts once stages two and three agree
    logic [2:0] stb_s_ff, clk_s_ff, din_s_ff, ka_s_ff, kb_s_ff;
    logic stb_ff, sclk_ff;
    logic din_ff, ka_ff, kb_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stb_s_ff <= 3'h7;
            clk_s_ff <= 3'h7;
            din_s_ff <= 3'h0;
            ka_s_ff <= 3'h0;
            kb_s_ff <= 3'h0;
            stb_ff <= 1'b1;
            sclk_ff <= 1'b1;
            din_ff <= 1'b0;
            ka_ff <= 1'b0;
            kb_ff <= 1'b0;
        end else begin
            stb_s_ff <= {stb_s_ff[1:0], frame_select};
            clk_s_ff <= {clk_s_ff[1:0], shift_clk};
            din_s_ff <= {din_s_ff[1:0], data_in};
            ka_s_ff <= {ka_s_ff[1:0], key_return_a};
            kb_s_ff <= {kb_s_ff[1:0], key_return_b};
            if (stb_s_ff[1] == stb_s_ff[2]) stb_ff <= stb_s_ff[2];
            if (clk_s_ff[1] == clk_s_ff[2]) sclk_ff <= clk_s_ff[2];
            if (din_s_ff[1] == din_s_ff[2]) din_ff <= din_s_ff[2];
            if (ka_s_ff[1] == ka_s_ff[2]) ka_ff <= ka_s_ff[2];
            if (kb_s_ff[1] == kb_s_ff[2]) kb_ff <= kb_s_ff[2];
        end
    end
    wire nxt_sclk = (clk_s_ff[1] == clk_s_ff[2]) ? clk_s_ff[2] : sclk_ff;
    wire active = !stb_ff;
    wire rise = active && nxt_sclk && !sclk_ff;
    wire fall = active && !nxt_sclk && sclk_ff;
    wire din_bit = din_ff;

    // receive shifter, lsb first
    logic [7:0] sh_ff;
    logic [2:0] bit_ff;
    logic first_ff;
    logic read_mode_ff;
    logic fixed_addr_ff;
    wire [7:0] rx_byte = {din_bit, sh_ff[7:1]};
    wire byte_done = rise && (bit_ff == 3'h7);
    wire is_cmd = byte_done && first_ff;
    wire is_data = byte_done && !first_ff && !read_mode_ff;
    wire [1:0] cmd_class = rx_byte[7:6];
    always_ff @(posedge clk) begin
        if (!rst_n || stb_ff) begin
            sh_ff <= 8'h00;
            bit_ff <= 3'h0;
            first_ff <= 1'b1;
        end else if (rise) begin
            sh_ff <= rx_byte;
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) first_ff <= 1'b0;
        end
    end

    // command decode
    logic [3:0] addr_ff;
    ledsc_disp_t disp_ff;
    logic [1:0] mode_ff;
    logic read_req_ff;
    wire cmd_mode = is_cmd && (cmd_class == 2'h0);
    wire cmd_data = is_cmd && (cmd_class == 2'h1);
    wire cmd_addr = is_cmd && (cmd_class == 2'h3);
    wire cmd_ctrl = is_cmd && (cmd_class == 2'h2);
    wire addr_ok = (addr_ff <= `LEDSC_ADDR_LAST);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            disp_ff <= '{on: 1'b0, pulse_width: `LEDSC_PW_RESET};
            mode_ff <= `LEDSC_MODE_RESET;
            read_mode_ff <= 1'b0;
            fixed_addr_ff <= 1'b0;
        end else begin
            if (cmd_mode) mode_ff <= rx_byte[1:0];
            if (cmd_data) begin
                read_mode_ff <= rx_byte[1];
                fixed_addr_ff <= rx_byte[2];
            end
            // 80 hex gives on=0 and narrowest width; key scan is untouched
            if (cmd_ctrl) disp_ff <= '{on: rx_byte[3], pulse_width: rx_byte[2:0]};
        end
    end

    // write bytes queue behind the shifter so ram update is decoupled
    logic fifo_valid, fifo_in_ready;
    logic [7:0] fifo_data;
    wire fifo_pop = fifo_valid;
    ledsc_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(is_data && addr_ok),
        .in_ready(fifo_in_ready),
        .in_data(rx_byte),
        .out_valid(fifo_valid),
        .out_ready(1'b1),
        .out_data(fifo_data)
    );
    // address counter runs at receive time so invalid-address bytes drop at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_ff <= 4'h0;
        end else if (cmd_addr) begin
            addr_ff <= rx_byte[3:0];
        end else if (is_data && addr_ok && fifo_in_ready && !fixed_addr_ff) begin
            addr_ff <= addr_ff + 4'h1;
        end
    end
    logic [3:0] wa_ff [8];
    logic [2:0] wa_w_ff, wa_r_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wa_w_ff <= 3'h0;
            wa_r_ff <= 3'h0;
        end else begin
            if (is_data && addr_ok && fifo_in_ready) wa_w_ff <= wa_w_ff + 3'h1;
            if (fifo_pop) wa_r_ff <= wa_r_ff + 3'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (is_data && addr_ok && fifo_in_ready) wa_ff[wa_w_ff] <= addr_ff;
    end
    logic [7:0] ram_ff [`LEDSC_RAM_DEPTH];
    always_ff @(posedge clk) begin
        if (fifo_pop) ram_ff[wa_ff[wa_r_ff]] <= fifo_data;
    end

    // key scan: frame timer, source walk, two frames per scan
    logic [$clog2(FRAME_CYC+1)-1:0] fcnt_ff;
    logic [3:0] src_ff;
    logic frame_ff;
    logic [9:0] ksrc_ff;
    logic [9:0] ka_cap_ff, kb_cap_ff;
    logic [39:0] key_ram_ff;
    logic done_ff;
    localparam int SLOT = FRAME_CYC / 10;
    wire fend = (fcnt_ff == ($clog2(FRAME_CYC+1))'(FRAME_CYC - 1));
    wire slot_end = (fcnt_ff % ($clog2(FRAME_CYC+1))'(SLOT)) == ($clog2(FRAME_CYC+1))'(SLOT - 1);
    wire [39:0] key_pack;
    genvar g;
    generate
        for (g = 0; g < `LEDSC_KEY_BYTES; g++) begin : g_kb
            assign key_pack[8*g +: 8] = {3'h0, kb_cap_ff[2*g+1], ka_cap_ff[2*g+1], 1'b0,
                                          kb_cap_ff[2*g], ka_cap_ff[2*g]};
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fcnt_ff <= '0;
            src_ff <= 4'h0;
            frame_ff <= 1'b0;
            ksrc_ff <= 10'h001;
            ka_cap_ff <= 10'h000;
            kb_cap_ff <= 10'h000;
            key_ram_ff <= 40'h0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            fcnt_ff <= fend ? '0 : fcnt_ff + 1'b1;
            if (slot_end && !frame_ff && src_ff < 4'hA) begin
                ka_cap_ff[src_ff] <= ka_ff;
                kb_cap_ff[src_ff] <= kb_ff;
                src_ff <= src_ff + 4'h1;
                ksrc_ff <= {ksrc_ff[8:0], 1'b0};
            end
            if (fend) begin
                frame_ff <= !frame_ff;
                src_ff <= 4'h0;
                ksrc_ff <= 10'h001;
                if (frame_ff) begin
                    key_ram_ff <= key_pack;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    // read shifter: loads on the read command, shifts on falling edges
    logic [39:0] tx_ff;
    logic [2:0] tbit_ff;
    logic rd_act_ff;
    logic oe_ff;
    always_ff @(posedge clk) begin
        if (!rst_n || stb_ff) begin
            rd_act_ff <= 1'b0;
            oe_ff <= 1'b0;
            tbit_ff <= 3'h0;
            tx_ff <= 40'h0;
        end else if (cmd_data && rx_byte[1]) begin
            rd_act_ff <= 1'b1;
            tx_ff <= key_ram_ff;
        end else if (rd_act_ff && fall) begin
            // a one bit releases the line; the pull-up makes the high
            oe_ff <= !tx_ff[0];
            tx_ff <= {1'b0, tx_ff[39:1]};
            tbit_ff <= tbit_ff + 3'h1;
        end else if (rd_act_ff && rise && tbit_ff == 3'h0) begin
            oe_ff <= 1'b0;
        end
    end

    // outputs from flops, except data_out which is tied low
    logic [7:0] rdd_ff;
    logic [3:0] rda_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdd_ff <= 8'h00;
            rda_ff <= 4'h0;
        end else begin
            rda_ff <= addr_ff;
            rdd_ff <= addr_ok ? ram_ff[addr_ff] : 8'h00;
        end
    end
    assign data_out = 1'b0;
    assign data_oe = oe_ff;
    assign key_source_line = ksrc_ff;
    assign disp_ctrl = disp_ff;
    assign disp_mode = mode_ff;
    assign ram_rd_addr = rda_ff;
    assign ram_rd_data = rdd_ff;
    assign scan_done = done_ff;
endmodule

// ---- bench/ledsc_chk.sv ----
// port assertions for the led serial command block
`timescale 1ns/10ps
module ledsc_chk
    import ledsc_pkg::*;
#(
    parameter int FRAME_CYC = 100
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link pins
    input wire logic frame_select,
    input wire logic data_out,
    input wire logic data_oe,
    // display and scan state
    input wire logic [9:0] key_source_line,
    input wire ledsc_pkg::ledsc_disp_t disp_ctrl,
    input wire logic [1:0] disp_mode,
    input wire logic [3:0] ram_rd_addr,
    input wire logic [7:0] ram_rd_data,
    input wire logic scan_done
);
    // cycles since the last refresh pulse; the first pulse has no reference
    logic [15:0] gap_ff;
    logic seen_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gap_ff <= 16'h0000;
            seen_ff <= 1'b0;
        end else begin
            gap_ff <= scan_done ? 16'h0000 : gap_ff + 16'h0001;
            seen_ff <= seen_ff | scan_done;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence idle_s;
        frame_select [*6];
    endsequence
    reset_vals_a: assert property ($rose(rst_n) |-> disp_ctrl == 4'h0 && disp_mode == 2'h3)
        else $error("display state wrong after reset");
    drive_low_a: assert property (data_out == 1'b0)
        else $error("data line driven high");
    oe_release_a: assert property (idle_s |-> !data_oe)
        else $error("data line held low while idle");
    src_onehot_a: assert property ($onehot(key_source_line))
        else $error("key source not one-hot");
    scan_pulse_a: assert property (scan_done |=> !scan_done)
        else $error("refresh pulse too long");
    scan_period_a: assert property (scan_done && seen_ff |-> gap_ff == 16'(2 * FRAME_CYC - 1))
        else $error("refresh spacing not two frames");
    ram_range_a: assert property ((ram_rd_addr > 4'hD) [*2] |-> ram_rd_data == 8'h00)
        else $error("data shown at invalid address");
    idle_hold_a: assert property (idle_s |=> $stable(disp_ctrl) && $stable(disp_mode) && $stable(ram_rd_addr))
        else $error("state changed while strobe high");
endmodule
bind ledsc_top ledsc_chk #(.FRAME_CYC(FRAME_CYC)) ledsc_chk_inst (
    .clk(clk), .rst_n(rst_n), .frame_select(frame_select), .data_out(data_out), .data_oe(data_oe),
    .key_source_line(key_source_line), .disp_ctrl(disp_ctrl), .disp_mode(disp_mode),
    .ram_rd_addr(ram_rd_addr), .ram_rd_data(ram_rd_data), .scan_done(scan_done)
);

// ---- bench/ledsc_host.sv ----
// host controller model driving the strobe, shift clock and data line
`timescale 1ns/10ps
module ledsc_host (
    // system clock used to pace the 800 ns link clock
    input wire logic clk,
    // link pins
    output logic frame_select,
    output logic shift_clk,
    output logic din_drv,
    input wire logic data_oe
);
    initial begin
        frame_select = 1'b1;
        shift_clk = 1'b1;
        din_drv = 1'b1;
    end
    task automatic wait_half();
        repeat (4) @(negedge clk);
    endtask
    task automatic open_frame();
        @(negedge clk);
        frame_select = 1'b0;
        wait_half();
    endtask
    task automatic close_frame();
        wait_half();
        frame_select = 1'b1;
        din_drv = 1'b1;
        repeat (2) wait_half();
    endtask
    task automatic put_bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            shift_clk = 1'b0;
            din_drv = b[i];
            wait_half();
            shift_clk = 1'b1;
            wait_half();
        end
    endtask
    // released line reads high through the pull-up unless the device pulls it
    task automatic get_byte(output logic [7:0] b);
        din_drv = 1'b1;
        for (int i = 0; i < 8; i++) begin
            shift_clk = 1'b0;
            wait_half();
            shift_clk = 1'b1;
            repeat (2) @(negedge clk);
            b[i] = !data_oe;
            repeat (2) @(negedge clk);
        end
    endtask
    task automatic read_wait();
        repeat (8) @(negedge clk);
    endtask
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the led serial command block
`timescale 1ns/10ps
module tb;
    import ledsc_pkg::*;
    localparam int FRAME_CYC = 100;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic frame_select, shift_clk, din_drv, data_out, data_oe, scan_done;
    logic [9:0] key_source_line;
    logic [9:0] keys_a = 10'h2A5;
    logic [9:0] keys_b = 10'h13C;
    ledsc_disp_t disp_ctrl;
    logic [1:0] disp_mode;
    logic [3:0] ram_rd_addr;
    logic [7:0] ram_rd_data;
    int err_count = 0;
    int checks = 0;
    wire data_in = din_drv & !data_oe;
    wire key_return_a = |(key_source_line & keys_a);
    wire key_return_b = |(key_source_line & keys_b);
    always #50 clk = ~clk;
    ledsc_top #(.FRAME_CYC(FRAME_CYC)) ledsc_top_inst (
        .clk(clk), .rst_n(rst_n), .frame_select(frame_select), .shift_clk(shift_clk),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .key_return_a(key_return_a),
        .key_return_b(key_return_b), .key_source_line(key_source_line), .disp_ctrl(disp_ctrl),
        .disp_mode(disp_mode), .ram_rd_addr(ram_rd_addr), .ram_rd_data(ram_rd_data), .scan_done(scan_done)
    );
    ledsc_host ledsc_host_inst (
        .clk(clk), .frame_select(frame_select), .shift_clk(shift_clk), .din_drv(din_drv), .data_oe(data_oe)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // one frame: a command, then n data bytes stepping by step
    task automatic send(input logic [7:0] cmd, input int n, input logic [7:0] first, input logic [7:0] step);
        logic [7:0] d;
        d = first;
        ledsc_host_inst.open_frame();
        ledsc_host_inst.put_bits(cmd, 8);
        for (int i = 0; i < n; i++) begin
            ledsc_host_inst.put_bits(d, 8);
            d = d + step;
        end
        ledsc_host_inst.close_frame();
    endtask
    task automatic look(input logic [3:0] a, input logic [7:0] exp);
        send({4'hC, a}, 0, 8'h00, 8'h00);
        check(ram_rd_data, exp);
    endtask
    task automatic wait_scan();
        int n;
        n = 0;
        @(negedge clk);
        while (scan_done !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        check(n < 1000, 1'b1);
    endtask
    task automatic t_reset();
        check(disp_ctrl, 4'h0);
        check(disp_mode, 2'h3);
        check(data_oe, 1'b0);
        check(key_source_line, 10'h001);
        check(scan_done, 1'b0);
    endtask
    task automatic t_bulk();
        logic [7:0] e;
        send(8'h00, 0, 8'h00, 8'h00);
        check(disp_mode, 2'h0);
        send(8'h40, 0, 8'h00, 8'h00);
        send(8'hC0, 14, 8'h11, 8'h13);
        check(ram_rd_addr, 4'hE);
        check(ram_rd_data, 8'h00);
        send(8'h8F, 0, 8'h00, 8'h00);
        check(disp_ctrl, 4'hF);
        e = 8'h11;
        for (int a = 0; a < 14; a++) begin
            look(4'(a), e);
            e = e + 8'h13;
        end
    endtask
    task automatic t_single();
        send(8'hC3, 1, 8'h5A, 8'h00);
        send(8'hC9, 1, 8'hA5, 8'h00);
        send(8'hCE, 1, 8'h77, 8'h00);
        check(ram_rd_data, 8'h00);
        look(4'h3, 8'h5A);
        look(4'h9, 8'hA5);
        look(4'h4, 8'h5D);
        // fixed-address mode: both bytes land at 5, location 6 keeps its bulk value
        send(8'h44, 0, 8'h00, 8'h00);
        send(8'hC5, 2, 8'h33, 8'h11);
        look(4'h5, 8'h44);
        look(4'h6, 8'h83);
        send(8'h40, 0, 8'h00, 8'h00);
    endtask
    task automatic t_abort();
        ledsc_host_inst.put_bits(8'h80, 8);
        check(disp_ctrl, 4'hF);
        ledsc_host_inst.open_frame();
        ledsc_host_inst.put_bits(8'h80, 4);
        ledsc_host_inst.close_frame();
        send(8'h8A, 0, 8'h00, 8'h00);
        check(disp_ctrl, 4'hA);
        send(8'h80, 0, 8'h00, 8'h00);
        check(disp_ctrl, 4'h0);
        wait_scan();
    endtask
    task automatic t_read();
        logic [7:0] b;
        wait_scan();
        wait_scan();
        ledsc_host_inst.open_frame();
        ledsc_host_inst.put_bits(8'h42, 8);
        ledsc_host_inst.read_wait();
        for (int g = 0; g < 5; g++) begin
            ledsc_host_inst.get_byte(b);
            check(b, {3'b000, keys_b[2*g+1], keys_a[2*g+1], 1'b0, keys_b[2*g], keys_a[2*g]});
            check(data_oe, 1'b0);
        end
        ledsc_host_inst.close_frame();
        check(data_oe, 1'b0);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        t_reset();
        t_bulk();
        t_single();
        t_abort();
        t_read();
        summarize();
    end
    // the whole sequence needs well under a millisecond of link traffic
    initial begin
        #2_000_000;
        err_count++;
        summarize();
    end
endmodule
